//--- src/host_watchdog_health_monitor.sv
// watchdog with health monitor behind the host i/o port
`timescale 1ns/10ps
`include "wdt_consts.svh"
module host_watchdog_health_monitor #(
  parameter int PG_LOW_CYCLES = (`WDT_PG_LOW_MS * 1000000 +
    `WDT_SYS_PERIOD_NS - 1) / `WDT_SYS_PERIOD_NS,
  parameter int FAN_WINDOW_CYCLES = `WDT_FAN_WINDOW_MS *
    (1000000 / `WDT_SYS_PERIOD_NS),
  parameter int FAN_MIN_PULSES = `WDT_FAN_MIN_PULSES,
  parameter bit TEMP_PRESENT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [9:0] io_addr,
  input wire logic [7:0] io_data_in,
  output logic [7:0] io_data_out,
  output logic io_data_oe,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [9:0] base_select,
  input wire logic host_reset_in,
  input wire wdt_pkg::health_pins_type health_in,
  output logic irq_o,
  output logic irq_oe,
  output logic pwr_good_o,
  output logic pwr_good_oe,
  output logic iso_reset_out,
  output logic iso_reset_out_n,
  output logic ttl_reset,
  output logic ttl_reset_n,
  output logic heartbeat,
  output logic buzzer
);
  import wdt_pkg::*;

  localparam int IRQ_CYCLES = (`WDT_IRQ_PULSE_NS +
    `WDT_SYS_PERIOD_NS - 1) / `WDT_SYS_PERIOD_NS;
  localparam int HB_HALF_CYCLES = 1000000000 /
    (2 * `WDT_HEARTBEAT_HZ * `WDT_SYS_PERIOD_NS);
  localparam int PG_W = $clog2(PG_LOW_CYCLES + 1);
  localparam int FAN_W = $clog2(FAN_WINDOW_CYCLES + 1);
  localparam int IRQ_W = $clog2(IRQ_CYCLES + 1);
  localparam int HB_W = $clog2(HB_HALF_CYCLES + 1);
  localparam int PH = `WDT_PHASE_BITS;
  localparam logic [63:0] STEP64 =
    (64'(`WDT_COLOR_CLOCK_HZ) << PH) /
    (64'(`WDT_COLOR_DIVIDE) * 64'(`WDT_SYS_CLOCK_HZ));
  localparam logic [PH-1:0] PRESC_STEP = STEP64[PH-1:0];
  localparam pin_sample_type PINS_IDLE =
    '{rd_n: 1'b1, wr_n: 1'b1, default: '0};

  if (PG_LOW_CYCLES < 1 || FAN_WINDOW_CYCLES < 2 ||
      FAN_MIN_PULSES < 1 || FAN_MIN_PULSES > 255) begin : g_bad_params
    $error("watchdog monitor parameters out of range");
  end

  // pin sampling, two stages then an edge reference stage
  pin_sample_type raw_pins;
  pin_sample_type meta_ff;
  pin_sample_type pins_ff;
  pin_sample_type prev_ff;

  assign raw_pins = '{rd_n: io_rd_n, wr_n: io_wr_n,
                      host_reset: host_reset_in, addr: io_addr,
                      base: base_select, data: io_data_in,
                      health: health_in};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_ff <= PINS_IDLE;
      pins_ff <= PINS_IDLE;
      prev_ff <= PINS_IDLE;
    end else begin
      meta_ff <= raw_pins;
      pins_ff <= meta_ff;
      prev_ff <= pins_ff;
    end
  end

  // address decode against the selected base
  logic hit;
  logic [2:0] offs;
  logic wr_evt;
  logic rd_evt;
  logic rd_active;
  control_type wr_ctrl;

  assign hit = pins_ff.addr[9:3] == pins_ff.base[9:3];
  assign offs = pins_ff.addr[2:0];
  assign wr_evt = prev_ff.wr_n && !pins_ff.wr_n && hit;
  assign rd_evt = prev_ff.rd_n && !pins_ff.rd_n && hit;
  assign rd_active = !pins_ff.rd_n && hit;
  assign wr_ctrl = control_type'(pins_ff.data);

  // control register and watchdog state
  control_type control_ff;
  wd_state_type wd_state_ff;
  wd_state_type nxt_wd_state;
  logic wd_running;
  logic ctrl_wr;
  logic arm_cmd;
  logic disarm_cmd;
  logic reload_cmd;
  logic wd_restart;
  logic timeout;
  logic warn_evt;
  logic tripped;

  assign wd_running = wd_state_ff == WD_ARMED;
  assign tripped = (wd_state_ff == WD_TRIP_RESET) ||
                   (wd_state_ff == WD_TRIP_ALARM);
  assign ctrl_wr = wr_evt && (offs == `WDT_OFS_CONTROL);
  assign arm_cmd = ctrl_wr && wr_ctrl.arm &&
                   (wd_state_ff == WD_IDLE);
  assign disarm_cmd = ctrl_wr && !wr_ctrl.arm;
  assign reload_cmd = wr_evt && wd_running &&
                      (offs == `WDT_OFS_RELOAD_TEMP);
  assign wd_restart = arm_cmd || reload_cmd;

  // prescaler: phase step from the color clock rate over sixteen
  logic [PH-1:0] phase_ff;
  logic [PH:0] phase_sum;
  logic presc_tick_ff;

  assign phase_sum = {1'b0, phase_ff} + {1'b0, PRESC_STEP};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_ff <= '0;
      presc_tick_ff <= 1'b0;
    end else begin
      phase_ff <= phase_sum[PH-1:0];
      presc_tick_ff <= phase_sum[PH];
    end
  end

  // three counters with byte-paired load and read
  logic [2:0] cnt_load;
  logic [2:0] cnt_run;
  logic [2:0] cnt_tick;
  logic [2:0] cnt_term;
  logic [15:0] cnt_value [3];
  logic [7:0] rd_byte [3];

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_cnt
    logic wr_msb_ff;
    logic rd_msb_ff;
    logic [7:0] low_byte_ff;
    logic [15:0] prog_ff;
    logic wr_hit;
    logic rd_hit;
    logic prog_done;
    logic [15:0] load_val;

    assign wr_hit = wr_evt && (offs == 3'(gi));
    assign rd_hit = rd_evt && (offs == 3'(gi));
    assign prog_done = wr_hit && wr_msb_ff;
    assign load_val = prog_done ? {pins_ff.data, low_byte_ff} : prog_ff;

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        wr_msb_ff <= 1'b0;
        rd_msb_ff <= 1'b0;
        low_byte_ff <= 8'h00;
        prog_ff <= `WDT_COUNT_RESET;
      end else begin
        if (wr_hit) begin
          wr_msb_ff <= !wr_msb_ff;
        end
        if (wr_hit && !wr_msb_ff) begin
          low_byte_ff <= pins_ff.data;
        end
        if (prog_done) begin
          prog_ff <= load_val;
        end
        if (rd_hit) begin
          rd_msb_ff <= !rd_msb_ff;
        end
      end
    end

    assign cnt_load[gi] = prog_done || ((gi < 2) && wd_restart);
    assign cnt_run[gi] = (gi == 2) ? control_ff.counter2_mode1 :
                         wd_running;
    assign rd_byte[gi] = rd_msb_ff ? cnt_value[gi][15:8] :
                         cnt_value[gi][7:0];

    if (gi == 1) begin : g_chain
      assign cnt_tick[gi] = cnt_term[0];
    end else begin : g_presc
      assign cnt_tick[gi] = presc_tick_ff;
    end

    wdt_down_counter #(
      .WIDTH(16)
    ) u_counter (
      .sys_clk(sys_clk),
      .reset(reset),
      .load(cnt_load[gi]),
      .load_value(load_val),
      .run(cnt_run[gi]),
      .tick(cnt_tick[gi]),
      .count(cnt_value[gi]),
      .terminal(cnt_term[gi])
    );
  end

  // timeout and early warning; a reload in the same cycle cancels the timeout only
  assign timeout = cnt_term[1] && wd_running && !reload_cmd;
  assign warn_evt = cnt_term[0] && wd_running &&
                    (cnt_value[1] == `WDT_WARN_COUNT);

  always_comb begin
    nxt_wd_state = wd_state_ff;
    case (wd_state_ff)
      WD_IDLE: begin
        if (arm_cmd) begin
          nxt_wd_state = WD_ARMED;
        end
      end
      WD_ARMED: begin
        if (timeout && control_ff.alarm_action) begin
          nxt_wd_state = WD_TRIP_ALARM;
        end else if (timeout) begin
          nxt_wd_state = WD_TRIP_RESET;
        end else if (disarm_cmd) begin
          nxt_wd_state = WD_IDLE;
        end
      end
      WD_TRIP_RESET, WD_TRIP_ALARM: begin
        if (pins_ff.host_reset) begin
          nxt_wd_state = WD_IDLE;
        end
      end
      default: begin
        nxt_wd_state = WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wd_state_ff <= WD_IDLE;
      control_ff <= control_type'(`WDT_CONTROL_RESET);
    end else begin
      wd_state_ff <= nxt_wd_state;
      if (ctrl_wr) begin
        control_ff <= wr_ctrl;
      end
    end
  end

  // power-good pull-down for the reset action
  logic [PG_W-1:0] pg_cnt_ff;
  logic [PG_W-1:0] nxt_pg_cnt;
  logic pg_start;

  assign pg_start = timeout && !control_ff.alarm_action;
  assign nxt_pg_cnt = pg_start ? PG_W'(PG_LOW_CYCLES) :
                      (pg_cnt_ff != '0) ? pg_cnt_ff - PG_W'(1) :
                      pg_cnt_ff;

  // health inputs and fan tachometer window
  logic over_rise;
  logic under_rise;
  logic hot_rise;
  logic iso_change;
  logic tach_rise;
  logic fan_fail;
  logic win_end;
  logic [FAN_W-1:0] fan_win_ff;
  logic [7:0] fan_pulses_ff;
  logic fan_good_ff;
  logic nxt_fan_good;

  assign over_rise = pins_ff.health.supply_over &&
                     !prev_ff.health.supply_over;
  assign under_rise = pins_ff.health.supply_under &&
                      !prev_ff.health.supply_under;
  assign hot_rise = pins_ff.health.temp_hot &&
                    !prev_ff.health.temp_hot;
  assign iso_change =
    (pins_ff.health.isolated_input_one !=
     prev_ff.health.isolated_input_one) ||
    (pins_ff.health.isolated_input_zero !=
     prev_ff.health.isolated_input_zero);
  assign tach_rise = pins_ff.health.fan_tach && !prev_ff.health.fan_tach;
  assign win_end = fan_win_ff == FAN_W'(FAN_WINDOW_CYCLES - 1);
  assign nxt_fan_good = win_end ?
    (fan_pulses_ff >= 8'(FAN_MIN_PULSES)) : fan_good_ff;
  assign fan_fail = fan_good_ff && !nxt_fan_good;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fan_win_ff <= '0;
      fan_pulses_ff <= 8'h00;
      fan_good_ff <= 1'b1;
    end else begin
      fan_good_ff <= nxt_fan_good;
      if (win_end) begin
        fan_win_ff <= '0;
        fan_pulses_ff <= 8'h00;
      end else begin
        fan_win_ff <= fan_win_ff + FAN_W'(1);
        if (tach_rise && fan_pulses_ff != 8'hFF) begin
          fan_pulses_ff <= fan_pulses_ff + 8'h01;
        end
      end
    end
  end

  // interrupt pulse and sticky status flags
  logic irq_req;
  logic [IRQ_W-1:0] irq_cnt_ff;
  logic [IRQ_W-1:0] nxt_irq_cnt;
  logic refresh_due_ff;
  logic irq_seen_ff;
  logic status_rd;

  assign irq_req = (warn_evt && control_ff.warn_irq_en) ||
                   ((over_rise || under_rise || hot_rise) &&
                    control_ff.health_irq_en) ||
                   iso_change || fan_fail;
  assign nxt_irq_cnt = (irq_req && irq_cnt_ff == '0) ?
                       IRQ_W'(IRQ_CYCLES) :
                       (irq_cnt_ff != '0) ? irq_cnt_ff - IRQ_W'(1) :
                       irq_cnt_ff;
  assign status_rd = rd_evt && (offs == `WDT_OFS_STATUS);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_cnt_ff <= '0;
      refresh_due_ff <= 1'b0;
      irq_seen_ff <= 1'b0;
      pg_cnt_ff <= '0;
    end else begin
      irq_cnt_ff <= nxt_irq_cnt;
      pg_cnt_ff <= nxt_pg_cnt;
      if (warn_evt) begin
        refresh_due_ff <= 1'b1;
      end else if (wd_restart) begin
        refresh_due_ff <= 1'b0;
      end
      if (irq_req) begin
        irq_seen_ff <= 1'b1;
      end else if (status_rd) begin
        irq_seen_ff <= 1'b0;
      end
    end
  end

  // status byte
  status_type status_now;

  assign status_now.refresh_reminder_n = !refresh_due_ff;
  assign status_now.temperature_ok = !pins_ff.health.temp_hot;
  assign status_now.iso_input_one_state =
    pins_ff.health.isolated_input_one;
  assign status_now.iso_input_zero_state =
    pins_ff.health.isolated_input_zero;
  assign status_now.fan_ok_n = !fan_good_ff;
  assign status_now.supply_over_n = !pins_ff.health.supply_over;
  assign status_now.supply_under_n = !pins_ff.health.supply_under;
  assign status_now.irq_raised_n = !irq_seen_ff;

  // read data selection
  logic [7:0] rd_data;

  always_comb begin
    rd_data = 8'h00;
    if (offs == `WDT_OFS_COUNT0) begin
      rd_data = rd_byte[0];
    end else if (offs == `WDT_OFS_COUNT1) begin
      rd_data = rd_byte[1];
    end else if (offs == `WDT_OFS_COUNT2) begin
      rd_data = rd_byte[2];
    end else if (offs == `WDT_OFS_CONTROL) begin
      rd_data = control_ff;
    end else if (offs == `WDT_OFS_ISO_BUZZ_ON) begin
      rd_data = {6'h00, pins_ff.health.isolated_input_one,
                 pins_ff.health.isolated_input_zero};
    end else if (offs == `WDT_OFS_STATUS) begin
      rd_data = status_now;
    end else if (offs == `WDT_OFS_RELOAD_TEMP && TEMP_PRESENT) begin
      rd_data = pins_ff.health.temp_code;
    end
  end

  // buzzer control
  logic buzz_sw_ff;
  logic buzz_on_wr;
  logic buzz_off_wr;

  assign buzz_on_wr = wr_evt && (offs == `WDT_OFS_ISO_BUZZ_ON);
  assign buzz_off_wr = wr_evt && (offs == `WDT_OFS_BUZZ_OFF);

  // heartbeat divider
  logic [HB_W-1:0] hb_cnt_ff;
  logic hb_wrap;

  assign hb_wrap = hb_cnt_ff == HB_W'(HB_HALF_CYCLES - 1);

  // output registers
  logic [7:0] data_out_ff;
  logic data_oe_ff;
  logic irq_drive_ff;
  logic pg_drive_ff;
  logic trip_out_ff;
  logic hb_ff;
  logic buzzer_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_out_ff <= 8'h00;
      data_oe_ff <= 1'b0;
      irq_drive_ff <= 1'b0;
      pg_drive_ff <= 1'b0;
      trip_out_ff <= 1'b0;
      hb_cnt_ff <= '0;
      hb_ff <= 1'b0;
      buzz_sw_ff <= 1'b0;
      buzzer_ff <= 1'b0;
    end else begin
      if (rd_evt) begin
        data_out_ff <= rd_data;
      end
      data_oe_ff <= rd_active;
      irq_drive_ff <= nxt_irq_cnt != '0;
      pg_drive_ff <= nxt_pg_cnt != '0;
      trip_out_ff <= tripped;
      if (!wd_running) begin
        hb_cnt_ff <= '0;
        hb_ff <= 1'b0;
      end else if (hb_wrap) begin
        hb_cnt_ff <= '0;
        hb_ff <= !hb_ff;
      end else begin
        hb_cnt_ff <= hb_cnt_ff + HB_W'(1);
      end
      if (!control_ff.counter2_mode1 || buzz_off_wr) begin
        buzz_sw_ff <= 1'b0;
      end else if (buzz_on_wr) begin
        buzz_sw_ff <= 1'b1;
      end
      buzzer_ff <= control_ff.counter2_mode1 &&
                   (buzz_sw_ff || (control_ff.alarm_enable &&
                    wd_state_ff == WD_TRIP_ALARM));
    end
  end

  assign io_data_out = data_out_ff;
  assign io_data_oe = data_oe_ff;
  assign irq_o = irq_drive_ff;
  assign irq_oe = irq_drive_ff;
  assign pwr_good_o = 1'b0 & pg_drive_ff;
  assign pwr_good_oe = pg_drive_ff;
  assign iso_reset_out = trip_out_ff;
  assign iso_reset_out_n = !trip_out_ff;
  assign ttl_reset = trip_out_ff;
  assign ttl_reset_n = !trip_out_ff;
  assign heartbeat = hb_ff;
  assign buzzer = buzzer_ff;
endmodule

//--- src/wdt_consts.svh
// offsets, reset values and timing figures of the watchdog monitor
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_OFS_COUNT0 3'h0
`define WDT_OFS_COUNT1 3'h1
`define WDT_OFS_COUNT2 3'h2
`define WDT_OFS_CONTROL 3'h3
`define WDT_OFS_ISO_BUZZ_ON 3'h4
`define WDT_OFS_BUZZ_OFF 3'h5
`define WDT_OFS_STATUS 3'h6
`define WDT_OFS_RELOAD_TEMP 3'h7
`define WDT_CONTROL_RESET 8'h00
`define WDT_COUNT_RESET 16'h0000
`define WDT_WARN_COUNT 16'h0002
`define WDT_SYS_PERIOD_NS 40
`define WDT_SYS_CLOCK_HZ 25000000
`define WDT_COLOR_CLOCK_HZ 14318180
`define WDT_COLOR_DIVIDE 16
`define WDT_PHASE_BITS 24
`define WDT_IRQ_PULSE_NS 1000
`define WDT_PG_LOW_MS 16
`define WDT_HEARTBEAT_HZ 56000
`define WDT_FAN_WINDOW_MS 1000
`define WDT_FAN_MIN_PULSES 50
`endif

//--- src/wdt_down_counter.sv
// reloadable down counter; a load value of zero divides by 2**WIDTH
`timescale 1ns/10ps
module wdt_down_counter #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  input wire logic tick,
  output logic [WIDTH-1:0] count,
  output logic terminal
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic terminal_ff;
  logic step;
  logic at_end;

  if (WIDTH != 16) begin : g_bad_width
    $error("wdt_down_counter serves only 16-bit counting");
  end

  assign step = run && tick;
  assign at_end = step && (count_ff == WIDTH'(1));
  assign nxt_count = load ? load_value :
                     at_end ? load_value :
                     step ? count_ff - WIDTH'(1) : count_ff;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_ff <= '0;
      terminal_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      terminal_ff <= at_end && !load;
    end
  end

  assign count = count_ff;
  assign terminal = terminal_ff;
endmodule

//--- src/wdt_pkg.sv
// types shared by the watchdog monitor files
package wdt_pkg;
  typedef enum logic [3:0] {
    WD_IDLE = 4'b0001,
    WD_ARMED = 4'b0010,
    WD_TRIP_RESET = 4'b0100,
    WD_TRIP_ALARM = 4'b1000
  } wd_state_type;

  typedef struct packed {
    logic [1:0] spare;
    logic health_irq_en;
    logic warn_irq_en;
    logic counter2_mode1;
    logic alarm_enable;
    logic alarm_action;
    logic arm;
  } control_type;

  typedef struct packed {
    logic irq_raised_n;
    logic supply_under_n;
    logic supply_over_n;
    logic fan_ok_n;
    logic iso_input_zero_state;
    logic iso_input_one_state;
    logic temperature_ok;
    logic refresh_reminder_n;
  } status_type;

  typedef struct packed {
    logic supply_over;
    logic supply_under;
    logic temp_hot;
    logic isolated_input_one;
    logic isolated_input_zero;
    logic fan_tach;
    logic [7:0] temp_code;
  } health_pins_type;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic host_reset;
    logic [9:0] addr;
    logic [9:0] base;
    logic [7:0] data;
    health_pins_type health;
  } pin_sample_type;
endpackage

//--- verif/host_bus_model.sv
// host i/o bus master model driving the monitor's bus pins
`timescale 1ns/10ps
module host_bus_model (
  input wire logic sys_clk,
  output logic [9:0] io_addr,
  output logic [7:0] io_data_in,
  output logic io_rd_n,
  output logic io_wr_n
);
  initial begin
    io_addr = 10'h000;
    io_data_in = 8'h00;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
  end

  // one strobe, held low six edges, then four edges high
  task automatic cycle(input logic [9:0] a, input logic [7:0] d,
                       input bit wr);
    @(posedge sys_clk);
    #1;
    io_addr = a;
    io_data_in = d;
    if (wr) begin
      io_wr_n = 1'b0;
    end else begin
      io_rd_n = 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    #1;
    io_wr_n = 1'b1;
    io_rd_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    // released data lines show the inverse of the last value
    io_data_in = ~d;
  endtask

  // software refresh of both watchdog counters
  task automatic reload(input logic [9:0] base);
    cycle(base + 10'h007, 8'h00, 1'b1);
  endtask
endmodule

//--- verif/tb_top.sv
// self-checking bench of the watchdog health monitor
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import wdt_pkg::*;
  localparam logic [9:0] BASE = 10'h2A8;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic host_reset_in = 1'b0;
  logic [9:0] base_select = BASE;
  health_pins_type hp = '0;
  wire [9:0] io_addr;
  wire [7:0] io_data_in;
  wire io_rd_n;
  wire io_wr_n;
  logic [7:0] io_data_out;
  logic io_data_oe, irq_o, irq_oe, pwr_good_o, pwr_good_oe, buzzer;
  logic iso_reset_out, iso_reset_out_n, ttl_reset, ttl_reset_n, heartbeat;
  logic oe_q = 1'b0;
  logic fan_run = 1'b1;
  logic [7:0] exp_b;
  logic irq_seen = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  int pg_cnt = 0;
  logic [31:0] r;
  logic chg;

  always #20 sys_clk = ~sys_clk;
  // fan tachometer: 5 pulses per 200-cycle window while fan_run is set
  always begin
    repeat (20) @(posedge sys_clk);
    #1;
    if (fan_run) hp.fan_tach = ~hp.fan_tach;
  end

  host_bus_model i_host (.sys_clk(sys_clk), .io_addr(io_addr),
    .io_data_in(io_data_in), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n));

  host_watchdog_health_monitor #(.PG_LOW_CYCLES(20),
    .FAN_WINDOW_CYCLES(200), .FAN_MIN_PULSES(2)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .io_addr(io_addr),
    .io_data_in(io_data_in), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
    .base_select(base_select), .host_reset_in(host_reset_in),
    .health_in(hp), .irq_o(irq_o), .irq_oe(irq_oe),
    .pwr_good_o(pwr_good_o), .pwr_good_oe(pwr_good_oe),
    .iso_reset_out(iso_reset_out), .iso_reset_out_n(iso_reset_out_n),
    .ttl_reset(ttl_reset), .ttl_reset_n(ttl_reset_n),
    .heartbeat(heartbeat), .buzzer(buzzer));

  // read answers are compared against the oldest expected byte
  always @(posedge sys_clk) begin
    oe_q <= io_data_oe;
    if (pwr_good_oe) pg_cnt++;
    if (irq_oe && !ttl_reset) irq_seen = 1'b1;
    if (io_data_oe && !oe_q) begin
      if (exp_q.size() == 0) begin
        `CHK(io_data_out, 8'hXX)
      end else begin
        exp_b = exp_q.pop_front();
        `CHK(io_data_out, exp_b)
      end
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    i_host.cycle(BASE + {7'h00, o}, d, 1'b1);
  endtask

  task automatic rd(input logic [2:0] o, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.cycle(BASE + {7'h00, o}, 8'h00, 1'b0);
  endtask

  function automatic logic [7:0] stat(input logic irq_n);
    return {irq_n, ~hp.supply_under, ~hp.supply_over, !fan_run,
      hp.isolated_input_zero, hp.isolated_input_one, ~hp.temp_hot, 1'b1};
  endfunction

  task automatic trip_and_clear(input logic [7:0] ctrl);
    int n;
    n = 0;
    pg_cnt = 0;
    irq_seen = 1'b0;
    wr(3'h3, ctrl);
    while (ttl_reset !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(ttl_reset, 1'b1)
    `CHK(n >= 150 && n <= 260, 1'b1)
    repeat (200) @(posedge sys_clk);
    #1;
    `CHK(ttl_reset, 1'b1)
    `CHK(irq_seen, 1'b1)
    `CHK(pg_cnt, ctrl[1] ? 0 : 20)
    `CHK(buzzer, ctrl[1])
    rd(3'h6, stat(1'b0) & 8'hFE);
    host_reset_in = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    host_reset_in = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(iso_reset_out, 1'b0)
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(97534));
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rd(3'h0, 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h3, 8'h08);
    rd(3'h3, 8'h08);
    i_host.cycle(BASE + 10'h008, 8'h00, 1'b0);
    wr(3'h4, 8'h00);
    `CHK(buzzer, 1'b1)
    wr(3'h5, 8'h00);
    `CHK(buzzer, 1'b0)
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    `CHK(buzzer, 1'b0)
    base_select = 10'h3F8;
    repeat (4) @(posedge sys_clk);
    #1;
    exp_q.push_back(8'h00);
    i_host.cycle(10'h3FB, 8'h00, 1'b0);
    base_select = BASE;
    $display("register and buzzer test done");
    for (int i = 0; i < 4; i++) begin
      r = i == 0 ? 32'h0 : $urandom;
      chg = {hp.isolated_input_one, hp.isolated_input_zero} != r[4:3];
      {hp.supply_over, hp.supply_under, hp.temp_hot} = r[2:0];
      {hp.isolated_input_one, hp.isolated_input_zero} = r[4:3];
      hp.temp_code = r[15:8];
      repeat (40) @(posedge sys_clk);
      rd(3'h6, stat(!chg));
      rd(3'h6, stat(1'b1));
      rd(3'h4, {6'h00, r[4:3]});
      rd(3'h7, r[15:8]);
    end
    {hp.supply_over, hp.supply_under, hp.temp_hot} = 3'b000;
    wr(3'h3, 8'h20);
    hp.temp_hot = 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(3'h6, stat(1'b0));
    fan_run = 1'b0;
    repeat (450) @(posedge sys_clk);
    rd(3'h6, stat(1'b0));
    fan_run = 1'b1;
    repeat (450) @(posedge sys_clk);
    rd(3'h6, stat(1'b1));
    $display("health status test done");
    wr(3'h0, 8'h02);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h04);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h11);
    repeat (8) begin
      repeat (30) @(posedge sys_clk);
      i_host.reload(BASE);
    end
    `CHK(ttl_reset, 1'b0)
    trip_and_clear(8'h11);
    $display("reset action test done");
    trip_and_clear(8'h1F);
    $display("alarm action test done");
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule

//--- verif/wdt_asserts.sv
// concurrent checks on the watchdog monitor ports
`timescale 1ns/10ps
module wdt_asserts #(
  parameter int PG_LOW_CYCLES = 400000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [9:0] io_addr,
  input wire logic io_rd_n,
  input wire logic [9:0] base_select,
  input wire logic io_data_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  input wire logic pwr_good_o,
  input wire logic pwr_good_oe,
  input wire logic iso_reset_out,
  input wire logic iso_reset_out_n,
  input wire logic ttl_reset,
  input wire logic ttl_reset_n,
  input wire logic heartbeat
);
  int irq_len_ff;
  int pg_len_ff;
  int hb_len_ff;
  // lengths of the current high runs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_len_ff <= 0;
      pg_len_ff <= 0;
      hb_len_ff <= 0;
    end else begin
      irq_len_ff <= irq_oe ? irq_len_ff + 1 : 0;
      pg_len_ff <= pwr_good_oe ? pg_len_ff + 1 : 0;
      hb_len_ff <= heartbeat ? hb_len_ff + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_read_answer;
    $rose(io_data_oe);
  endsequence
  sequence s_beat_rise;
    $rose(heartbeat);
  endsequence
  a_irq_pulse_len: assert property (!irq_oe && irq_len_ff != 0 |->
    irq_len_ff == 25) else $error("irq pulse length wrong");
  a_irq_drive_high: assert property (irq_oe |-> irq_o)
    else $error("irq driven low");
  a_pg_pulse_len: assert property (!pwr_good_oe && pg_len_ff != 0 |->
    pg_len_ff == PG_LOW_CYCLES) else $error("power-good pulse length");
  a_pg_pull_low: assert property (pwr_good_oe |-> !pwr_good_o)
    else $error("power-good not pulled low");
  a_iso_pair_comp: assert property (iso_reset_out != iso_reset_out_n)
    else $error("isolated pair not complementary");
  a_ttl_flag_pair: assert property (ttl_reset == iso_reset_out &&
    ttl_reset_n == !ttl_reset) else $error("reset flag pair wrong");
  a_beat_off_trip: assert property (ttl_reset && $past(ttl_reset)
    |-> !heartbeat) else $error("heartbeat while tripped");
  a_beat_high_max: assert property (hb_len_ff <= 223)
    else $error("heartbeat high too long");
  a_beat_rise_hold: assert property (s_beat_rise |->
    (heartbeat || ttl_reset) [*8]) else $error("heartbeat glitch");
  a_read_in_block: assert property (s_read_answer |->
    $past(io_rd_n, 3) == 1'b0 &&
    $past(io_addr, 3) >> 3 == $past(base_select, 3) >> 3)
    else $error("read answered outside block");
endmodule

bind host_watchdog_health_monitor wdt_asserts #(
  .PG_LOW_CYCLES(PG_LOW_CYCLES)
) i_wdt_asserts (
  .sys_clk(sys_clk),
  .reset(reset),
  .io_addr(io_addr),
  .io_rd_n(io_rd_n),
  .base_select(base_select),
  .io_data_oe(io_data_oe),
  .irq_o(irq_o),
  .irq_oe(irq_oe),
  .pwr_good_o(pwr_good_o),
  .pwr_good_oe(pwr_good_oe),
  .iso_reset_out(iso_reset_out),
  .iso_reset_out_n(iso_reset_out_n),
  .ttl_reset(ttl_reset),
  .ttl_reset_n(ttl_reset_n),
  .heartbeat(heartbeat)
);
